/* hw/flr_pkg.sv */
package flr_pkg;

  // register port map
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] FAST_TRIM_OFS  = 8'h01;
  localparam logic [7:0] SLOW_TRIM_OFS  = 8'h02;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

  // self_program_control field positions
  localparam int PSE_BIT  = 0;
  localparam int LFRS_BIT = 3;
  localparam int TRS_BIT  = 5;

  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // arming windows in clock cycles
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  localparam logic [2:0] STORE_WIN = 3'h4;

  // lock/fuse pointer codes
  localparam logic [15:0] FUSE_LO_PTR  = 16'h0000;
  localparam logic [15:0] LOCK_PTR     = 16'h0001;
  localparam logic [15:0] FUSE_EXT_PTR = 16'h0002;
  localparam logic [15:0] FUSE_HI_PTR  = 16'h0003;

  // table byte addresses (core side, byte addressed)
  localparam logic [15:0] TBL_ID0     = 16'h0000;
  localparam logic [15:0] TBL_FAST    = 16'h0001;
  localparam logic [15:0] TBL_ID1     = 16'h0002;
  localparam logic [15:0] TBL_TEMP_A  = 16'h0003;
  localparam logic [15:0] TBL_ID2     = 16'h0004;
  localparam logic [15:0] TBL_TEMP_B  = 16'h0005;
  localparam logic [15:0] TBL_RSVD6   = 16'h0006;
  localparam logic [15:0] TBL_SLOW    = 16'h0007;
  localparam logic [15:0] TBL_TS_GAIN = 16'h002C;
  localparam logic [15:0] TBL_TS_OFFS = 16'h002D;
  localparam logic [7:0]  RESERVED_BYTE = 8'hFF;

  // flash geometry: 512 pages of 16 words
  localparam int FLASH_WORD_BITS = 4;
  localparam int FLASH_PAGE_BITS = 9;
  localparam int FLASH_WORD_LSB  = 1;
  localparam int FLASH_PAGE_LSB  = 5;

  // eeprom geometry: 64 pages of 4 bytes
  localparam int EE_ADDR_BITS = 8;
  localparam int EE_BYTE_BITS = 2;
  localparam int EE_PAGE_BITS = 6;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } flr_ans_s;

  typedef struct packed {
    logic                       we;
    logic [FLASH_PAGE_BITS-1:0] page;
    logic [FLASH_WORD_BITS-1:0] word;
    logic [15:0]                data;
  } flr_pbuf_s;

endpackage

/* hw/flr_readback.sv */
// Notes on behaviour
// [RQ1] core reads the table by byte index; external programmers use word addresses
// [RQ2] three-byte identification held in table, readable even when locked
// [RQ3] identification at bytes 0x00, 0x02, 0x04, calibration at odd bytes
// [RQ4] fast trim at 0x01, slow trim at 0x07, byte 0x06 reserved
// [RQ5] temperature trims at 0x03 and 0x05, one byte each
// [RQ6] sensor gain at 0x2C unsigned fixed point, offset at 0x2D
// [RQ7] sensor offset byte is signed two's complement
// [RQ8] during reset calibration bytes are copied into both trim registers
// [RQ9] programmed fuse and lock bits read as zero, unprogrammed as one
// [RQ10] arm lock/fuse read, load within three cycles returns fuse data
// [RQ11] armed bits clear on completion, no load in three, no store in four
// [RQ12] with arm bits clear, load returns ordinary flash contents
// [RQ13] armed load with pointer 0x0001 returns lock byte
// [RQ14] armed load with pointer 0x0000 returns low fuse byte
// [RQ15] armed load with pointer 0x0003 returns high fuse byte
// [RQ16] armed load with pointer 0x0002 returns extended fuse byte
// [RQ17] table read: pointer index, arm table select, load returns table byte
// [RQ18] flash is 512 pages of 16 words, word and page fields
// [RQ19] eeprom is 64 pages of 4 bytes, byte and page fields
// [RQ20] store-enable alone: next store writes word pair to page buffer
// [RQ21] reserved table indices return all ones
//
// Implementation choices: the register offsets and the plain strobed port.
module flr_readback
  import flr_pkg::*;
#(
  parameter logic [7:0] ID_BYTE0 = 8'hA5, // arbitrary value
  parameter logic [7:0] ID_BYTE1 = 8'h5A, // arbitrary value
  parameter logic [7:0] ID_BYTE2 = 8'h3C  // arbitrary value
) (
  input  wire logic        CLK,            // system clock
  input  wire logic        SRST,           // synchronous reset
  input  wire logic [7:0]  REG_ADDR,       // register address
  input  wire logic [7:0]  REG_WDATA,      // register write data
  input  wire logic        REG_WR,         // register write strobe
  input  wire logic        REG_RD,         // register read strobe
  output logic      [7:0]  REG_RDATA,      // register read data
  input  wire logic        LOAD_REQ,       // core load instruction
  input  wire logic        STORE_REQ,      // core program_store_instruction
  input  wire logic [15:0] PTR,            // pointer register
  input  wire logic [15:0] STORE_DATA,     // word pair to store
  input  wire logic [7:0]  FLASH_BYTE,     // flash byte at pointer
  output flr_ans_s         LOAD_ANS,       // load answer
  output flr_pbuf_s        PAGEBUF,        // page buffer write
  input  wire logic [7:0]  NV_LOCK_PROG,   // lock bits, 1 = programmed
  input  wire logic [7:0]  NV_FUSE_LO_PROG, // low fuses, 1 = programmed
  input  wire logic [7:0]  NV_FUSE_HI_PROG, // high fuses, 1 = programmed
  input  wire logic [7:0]  NV_FUSE_EXT_PROG, // extended fuses, 1 = programmed
  input  wire logic [7:0]  CAL_FAST,       // stored fast oscillator calibration
  input  wire logic [7:0]  CAL_SLOW,       // stored slow oscillator calibration
  input  wire logic [7:0]  CAL_TEMP_A,     // stored temperature trim a
  input  wire logic [7:0]  CAL_TEMP_B,     // stored temperature trim b
  input  wire logic [7:0]  CAL_TS_GAIN,    // stored sensor gain
  input  wire logic [7:0]  CAL_TS_OFFS,    // stored sensor offset
  output logic      [7:0]  FAST_OSC_TRIM,  // fast_osc_trim register
  output logic      [7:0]  SLOW_OSC_TRIM,  // slow_osc_trim register
  input  wire logic [7:0]  EE_ADDR,        // eeprom byte address
  output logic      [5:0]  EE_PAGE,        // eeprom page field
  output logic      [1:0]  EE_BYTE         // eeprom byte-in-page field
);

  if (EE_ADDR_BITS != EE_PAGE_BITS + EE_BYTE_BITS) begin : g_ee_chk
    $error("eeprom address split does not cover the address");
  end

  if (LOAD_WIN >= STORE_WIN) begin : g_win_chk
    $error("load window must end before the store window");
  end

  logic       pse_q;
  logic       lfrs_q;
  logic       trs_q;
  logic [2:0] age_q;
  logic       ctrl_wr;
  logic       armed_lf;
  logic       armed_ts;
  logic       store_only;
  logic       load_hit;
  logic       expire;
  logic [7:0] lf_byte;
  logic [7:0] tbl_byte;
  logic [7:0] ctrl_view;

  assign ctrl_wr    = REG_WR && (REG_ADDR == CTRL_OFS);
  assign armed_lf   = pse_q && lfrs_q;
  assign armed_ts   = pse_q && trs_q && !lfrs_q;
  assign store_only = pse_q && !lfrs_q && !trs_q;
  assign load_hit   = LOAD_REQ && (armed_lf || armed_ts) && (age_q < LOAD_WIN); // RQ10
  // read arms expire after the load window, store arm after the store window
  assign expire = (lfrs_q || trs_q) ? (age_q == LOAD_WIN - 3'h1)
                                    : (age_q == STORE_WIN - 3'h1); // RQ11

  // self_program_control arming and auto clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pse_q  <= CTRL_RST[PSE_BIT];
      lfrs_q <= CTRL_RST[LFRS_BIT];
      trs_q  <= CTRL_RST[TRS_BIT];
      age_q  <= 3'h0;
    end else if (ctrl_wr) begin
      pse_q  <= REG_WDATA[PSE_BIT];
      lfrs_q <= REG_WDATA[PSE_BIT] && REG_WDATA[LFRS_BIT];
      trs_q  <= REG_WDATA[PSE_BIT] && REG_WDATA[TRS_BIT];
      age_q  <= 3'h0;
    end else if (pse_q) begin
      if (load_hit || STORE_REQ || expire) begin // RQ11
        pse_q  <= 1'b0;
        lfrs_q <= 1'b0;
        trs_q  <= 1'b0;
        age_q  <= 3'h0;
      end else begin
        age_q <= age_q + 3'h1;
      end
    end
  end

  // lock and fuse readback, programmed bits read as zero
  always_comb begin
    case (PTR)
      LOCK_PTR:     lf_byte = ~NV_LOCK_PROG;     // RQ13 RQ9
      FUSE_LO_PTR:  lf_byte = ~NV_FUSE_LO_PROG;  // RQ14 RQ9
      FUSE_HI_PTR:  lf_byte = ~NV_FUSE_HI_PROG;  // RQ15 RQ9
      FUSE_EXT_PTR: lf_byte = ~NV_FUSE_EXT_PROG; // RQ16 RQ9
      default:      lf_byte = RESERVED_BYTE;
    endcase
  end

  // table indexed by byte address
  always_comb begin
    case (PTR) // RQ1 RQ17
      TBL_ID0:     tbl_byte = ID_BYTE0;    // RQ2 RQ3
      TBL_ID1:     tbl_byte = ID_BYTE1;    // RQ2 RQ3
      TBL_ID2:     tbl_byte = ID_BYTE2;    // RQ2 RQ3
      TBL_FAST:    tbl_byte = CAL_FAST;    // RQ4
      TBL_SLOW:    tbl_byte = CAL_SLOW;    // RQ4
      TBL_TEMP_A:  tbl_byte = CAL_TEMP_A;  // RQ5
      TBL_TEMP_B:  tbl_byte = CAL_TEMP_B;  // RQ5
      TBL_TS_GAIN: tbl_byte = CAL_TS_GAIN; // RQ6
      TBL_TS_OFFS: tbl_byte = CAL_TS_OFFS; // RQ6 RQ7
      TBL_RSVD6:   tbl_byte = RESERVED_BYTE; // RQ4 RQ21
      default:     tbl_byte = RESERVED_BYTE; // RQ21
    endcase
  end

  // load answer one cycle after the request
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LOAD_ANS <= '0;
    end else begin
      LOAD_ANS.valid <= LOAD_REQ;
      if (LOAD_REQ) begin
        if (load_hit && armed_lf) begin
          LOAD_ANS.data <= lf_byte; // RQ10
        end else if (load_hit) begin
          LOAD_ANS.data <= tbl_byte; // RQ17
        end else begin
          LOAD_ANS.data <= FLASH_BYTE; // RQ12
        end
      end
    end
  end

  // page buffer write, pointer lsb ignored
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PAGEBUF <= '0;
    end else begin
      PAGEBUF.we <= STORE_REQ && store_only; // RQ20
      if (STORE_REQ && store_only) begin
        PAGEBUF.word <= PTR[FLASH_WORD_LSB +: FLASH_WORD_BITS]; // RQ18
        PAGEBUF.page <= PTR[FLASH_PAGE_LSB +: FLASH_PAGE_BITS]; // RQ18
        PAGEBUF.data <= STORE_DATA; // RQ20
      end
    end
  end

  // eeprom address split
  always_ff @(posedge CLK) begin
    if (SRST) begin
      EE_PAGE <= '0;
      EE_BYTE <= '0;
    end else begin
      EE_PAGE <= EE_ADDR[EE_BYTE_BITS +: EE_PAGE_BITS]; // RQ19
      EE_BYTE <= EE_ADDR[EE_BYTE_BITS-1:0]; // RQ19
    end
  end

  // trims take the stored calibration while reset is held
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FAST_OSC_TRIM <= CAL_FAST; // RQ8
      SLOW_OSC_TRIM <= CAL_SLOW; // RQ8
    end else if (REG_WR) begin
      if (REG_ADDR == FAST_TRIM_OFS) begin
        FAST_OSC_TRIM <= REG_WDATA;
      end
      if (REG_ADDR == SLOW_TRIM_OFS) begin
        SLOW_OSC_TRIM <= REG_WDATA;
      end
    end
  end

  always_comb begin
    ctrl_view           = 8'h00;
    ctrl_view[PSE_BIT]  = pse_q;
    ctrl_view[LFRS_BIT] = lfrs_q;
    ctrl_view[TRS_BIT]  = trs_q;
  end

  // register read port
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= RDATA_RST;
    end else if (REG_RD) begin
      case (REG_ADDR)
        CTRL_OFS:      REG_RDATA <= ctrl_view;
        FAST_TRIM_OFS: REG_RDATA <= FAST_OSC_TRIM;
        SLOW_TRIM_OFS: REG_RDATA <= SLOW_OSC_TRIM;
        default:       REG_RDATA <= UNMAPPED_DATA;
      endcase
    end else begin
      REG_RDATA <= RDATA_RST;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  logic quiet;
  assign quiet = !LOAD_REQ && !STORE_REQ && !ctrl_wr;

  sequence s_arm_read;
    ctrl_wr && REG_WDATA[PSE_BIT] && REG_WDATA[LFRS_BIT];
  endsequence

  sequence s_arm_store;
    ctrl_wr && REG_WDATA[PSE_BIT] && !REG_WDATA[LFRS_BIT] && !REG_WDATA[TRS_BIT];
  endsequence

  sequence s_arm_table;
    ctrl_wr && REG_WDATA[PSE_BIT] && !REG_WDATA[LFRS_BIT] && REG_WDATA[TRS_BIT];
  endsequence

  sequence s_load_ts;
    LOAD_REQ && armed_ts;
  endsequence

  a_read_arm_expiry: assert property ( // RQ11
    s_arm_read ##1 quiet [*3] |=> !pse_q && !lfrs_q)
    else $error("read arm did not clear after three idle cycles");

  a_store_arm_expiry: assert property ( // RQ11
    s_arm_store ##1 quiet [*4] |=> !pse_q)
    else $error("store arm did not clear after four idle cycles");

  a_read_arm_window: assert property ( // RQ10
    s_arm_read ##1 quiet [*2] ##1 (LOAD_REQ && PTR == LOCK_PTR)
      |=> LOAD_ANS.valid && LOAD_ANS.data == ~$past(NV_LOCK_PROG))
    else $error("load on third cycle after arming lost lock data");

  a_lock_readback: assert property ( // RQ13
    LOAD_REQ && armed_lf && PTR == LOCK_PTR |=> LOAD_ANS.data == ~$past(NV_LOCK_PROG))
    else $error("lock byte readback wrong");

  a_fuse_low_read: assert property ( // RQ14
    LOAD_REQ && armed_lf && PTR == FUSE_LO_PTR
      |=> LOAD_ANS.data == ~$past(NV_FUSE_LO_PROG) ##1 !pse_q)
    else $error("low fuse readback wrong or arm not cleared");

  a_fuse_high_read: assert property ( // RQ15
    LOAD_REQ && armed_lf && PTR == FUSE_HI_PTR |=> LOAD_ANS.data == ~$past(NV_FUSE_HI_PROG))
    else $error("high fuse readback wrong");

  a_fuse_ext_read: assert property ( // RQ16
    LOAD_REQ && armed_lf && PTR == FUSE_EXT_PTR |=> LOAD_ANS.data == ~$past(NV_FUSE_EXT_PROG))
    else $error("extended fuse readback wrong");

  a_flash_normal: assert property ( // RQ12
    LOAD_REQ && !pse_q |=> LOAD_ANS.valid && LOAD_ANS.data == $past(FLASH_BYTE))
    else $error("unarmed load did not return flash");

  a_table_id_byte: assert property ( // RQ3
    LOAD_REQ && armed_ts && PTR == TBL_ID1 |=> LOAD_ANS.data == ID_BYTE1)
    else $error("table index 2 did not return identification byte 1");

  a_table_reserved: assert property ( // RQ21
    LOAD_REQ && armed_ts && PTR == TBL_RSVD6 |=> LOAD_ANS.data == RESERVED_BYTE)
    else $error("reserved table byte not all ones");

  a_trim_reset_copy: assert property ( // RQ8
    $fell(SRST) |-> FAST_OSC_TRIM == $past(CAL_FAST) && SLOW_OSC_TRIM == $past(CAL_SLOW))
    else $error("trims not loaded from calibration during reset");

  a_store_pagebuf: assert property ( // RQ20
    STORE_REQ && store_only |=> PAGEBUF.we && PAGEBUF.data == $past(STORE_DATA)
      && PAGEBUF.word == $past(PTR[4:1]) ##1 !PAGEBUF.we)
    else $error("store did not write page buffer once");

  a_table_id_zero: assert property ( // RQ2
    s_load_ts ##0 (PTR == TBL_ID0) |=> LOAD_ANS.data == ID_BYTE0)
    else $error("table index 0 did not return identification byte 0");

  a_table_id_two: assert property ( // RQ3
    s_load_ts ##0 (PTR == TBL_ID2) |=> LOAD_ANS.data == ID_BYTE2)
    else $error("table index 4 did not return identification byte 2");

  a_table_fast_cal: assert property ( // RQ4
    s_load_ts ##0 (PTR == TBL_FAST) |=> LOAD_ANS.data == $past(CAL_FAST))
    else $error("table fast calibration byte wrong");

  a_table_slow_cal: assert property ( // RQ4
    s_load_ts ##0 (PTR == TBL_SLOW) |=> LOAD_ANS.data == $past(CAL_SLOW))
    else $error("table slow calibration byte wrong");

  a_table_temp_a: assert property ( // RQ5
    s_load_ts ##0 (PTR == TBL_TEMP_A) |=> LOAD_ANS.data == $past(CAL_TEMP_A))
    else $error("table temperature trim a wrong");

  a_table_temp_b: assert property ( // RQ5
    s_load_ts ##0 (PTR == TBL_TEMP_B) |=> LOAD_ANS.data == $past(CAL_TEMP_B))
    else $error("table temperature trim b wrong");

  a_sensor_gain_byte: assert property ( // RQ6
    s_load_ts ##0 (PTR == TBL_TS_GAIN) |=> LOAD_ANS.data == $past(CAL_TS_GAIN))
    else $error("table sensor gain wrong");

  a_sensor_offs_byte: assert property ( // RQ7
    s_load_ts ##0 (PTR == TBL_TS_OFFS) |=> LOAD_ANS.data == $past(CAL_TS_OFFS))
    else $error("table sensor offset wrong");

  a_table_unlisted: assert property ( // RQ21
    s_load_ts ##0 (PTR > TBL_TS_OFFS) |=> LOAD_ANS.data == RESERVED_BYTE)
    else $error("unlisted table byte not all ones");

  a_load_arm_clear: assert property ( // RQ11
    LOAD_REQ && (armed_lf || armed_ts) && !ctrl_wr |=> !pse_q && !lfrs_q && !trs_q)
    else $error("arm bits not cleared after readback");

  a_store_clears_read: assert property ( // RQ11
    STORE_REQ && (armed_lf || armed_ts) && !ctrl_wr |=> !pse_q && !PAGEBUF.we)
    else $error("store while read armed did not clear the arm");

  a_ctrl_no_select: assert property ( // RQ10
    ctrl_wr && !REG_WDATA[PSE_BIT] |=> !pse_q && !lfrs_q && !trs_q)
    else $error("select bit stuck without store enable");

  a_load_valid_idle: assert property ( // RQ10
    !LOAD_REQ |=> !LOAD_ANS.valid)
    else $error("load answer valid without a load");

  a_ee_addr_split: assert property ( // RQ19
    1'b1 |=> EE_PAGE == $past(EE_ADDR[7:2]) && EE_BYTE == $past(EE_ADDR[1:0]))
    else $error("eeprom page or byte field wrong");

  a_store_page_field: assert property ( // RQ18
    STORE_REQ && store_only |=> PAGEBUF.page == $past(PTR[13:5]))
    else $error("page buffer page field wrong");

  a_store_refused: assert property ( // RQ20
    STORE_REQ && !store_only |=> !PAGEBUF.we)
    else $error("store without store-only arm wrote the page buffer");

  a_table_arm_window: assert property ( // RQ17
    s_arm_table ##1 quiet [*2] ##1 (LOAD_REQ && PTR == TBL_ID1) |=> LOAD_ANS.data == ID_BYTE1)
    else $error("table load on third cycle after arming lost table data");

  a_table_late_flash: assert property ( // RQ12
    s_arm_table ##1 quiet [*3] ##1 LOAD_REQ |=> LOAD_ANS.data == $past(FLASH_BYTE))
    else $error("late load after table arm did not return flash");

  a_read_late_flash: assert property ( // RQ12
    s_arm_read ##1 quiet [*3] ##1 LOAD_REQ |=> LOAD_ANS.data == $past(FLASH_BYTE))
    else $error("late load after fuse arm did not return flash");

  a_store_window_end: assert property ( // RQ20
    s_arm_store ##1 quiet [*3] ##1 STORE_REQ |=> PAGEBUF.we && PAGEBUF.data == $past(STORE_DATA))
    else $error("store on fourth cycle after arming was lost");

  a_lock_select_wins: assert property ( // RQ10
    LOAD_REQ && pse_q && lfrs_q && trs_q && PTR == LOCK_PTR |=> LOAD_ANS.data == ~$past(NV_LOCK_PROG))
    else $error("lock select did not win over table select");

endmodule // flr_readback

/* verification/flr_core_model.sv */
module flr_core_model (
  input  wire logic        CLK,        // system clock
  output logic             LOAD_REQ,   // load instruction
  output logic             STORE_REQ,  // store instruction
  output logic      [15:0] PTR,        // pointer register
  output logic      [15:0] STORE_DATA, // word pair to store
  output logic      [7:0]  FLASH_BYTE  // flash byte at pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    LOAD_REQ = 1'b0;
    STORE_REQ = 1'b0;
    PTR = 16'h0000;
    STORE_DATA = 16'h0000;
  end
  // flash contents seen by a load outside readback
  assign FLASH_BYTE = PTR[7:0] ^ 8'h96;
  // one request after gap idle cycles; byte index in pointer
  task automatic issue(input logic s, input logic [15:0] p, input logic [15:0] d, input int gap);
    repeat (gap) @(posedge CLK);
    PTR <= p;
    STORE_DATA <= d;
    if (s) STORE_REQ <= 1'b1;
    else LOAD_REQ <= 1'b1;
    @(posedge CLK);
    LOAD_REQ <= 1'b0;
    STORE_REQ <= 1'b0;
  endtask
endmodule // flr_core_model

/* verification/tb_top.sv */
module tb_top import flr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID0 = 8'h4B; // arbitrary value
  localparam logic [7:0] ID1 = 8'hC3; // arbitrary value
  localparam logic [7:0] ID2 = 8'h17; // arbitrary value
  logic        clk;
  logic        srst = 1'b1;
  logic        wr = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  ee_addr = 8'h00;
  logic [7:0]  cf = 8'h6A;
  logic [7:0]  cs = 8'h35;
  logic [7:0]  rdata, ft, stt;
  logic [5:0]  ee_page;
  logic [1:0]  ee_byte;
  logic        ld, st;
  logic [15:0] ptr, sdata;
  logic [7:0]  fbyte;
  flr_ans_s    ans;
  flr_pbuf_s   pbuf;
  logic [7:0]  prog [4] = '{8'h03, 8'h9D, 8'h20, 8'h01}; // lock, low, high, extended
  logic [15:0] fptr [4] = '{16'h0001, 16'h0000, 16'h0003, 16'h0002};
  logic [15:0] tidx [13] = '{16'h00, 16'h01, 16'h02, 16'h03, 16'h04, 16'h05, 16'h06,
                             16'h07, 16'h2C, 16'h2D, 16'h08, 16'h2E, 16'h40};
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  flr_readback #(.ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2)) flr_readback_i (
    .CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd_s), .REG_RDATA(rdata), .LOAD_REQ(ld), .STORE_REQ(st), .PTR(ptr),
    .STORE_DATA(sdata), .FLASH_BYTE(fbyte), .LOAD_ANS(ans), .PAGEBUF(pbuf),
    .NV_LOCK_PROG(prog[0]), .NV_FUSE_LO_PROG(prog[1]), .NV_FUSE_HI_PROG(prog[2]),
    .NV_FUSE_EXT_PROG(prog[3]), .CAL_FAST(cf), .CAL_SLOW(cs), .CAL_TEMP_A(8'hE2),
    .CAL_TEMP_B(8'h1D), .CAL_TS_GAIN(8'hFF), .CAL_TS_OFFS(8'h81), .FAST_OSC_TRIM(ft),
    .SLOW_OSC_TRIM(stt), .EE_ADDR(ee_addr), .EE_PAGE(ee_page), .EE_BYTE(ee_byte));
  flr_core_model flr_core_model_i (.CLK(clk), .LOAD_REQ(ld), .STORE_REQ(st), .PTR(ptr),
    .STORE_DATA(sdata), .FLASH_BYTE(fbyte));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(16'(rdata), 16'(e), "read data");
  endtask
  // arm (none if zero), load after gap cycles, judge the answer
  task automatic ldc(input logic [7:0] arm, input logic [15:0] p, input int gap,
                     input logic [7:0] e);
    if (arm != 8'h00) wrr(8'h00, arm);
    else @(posedge clk);
    flr_core_model_i.issue(1'b0, p, 16'h0000, gap);
    @(negedge clk);
    chk(16'(ans.valid), 16'h0001, "load valid");
    chk(16'(ans.data), 16'(e), "load data");
  endtask
  function automatic logic [7:0] tbl(input logic [15:0] i);
    case (i)
      16'h00: return ID0;
      16'h01: return cf;
      16'h02: return ID1;
      16'h03: return 8'hE2;
      16'h04: return ID2;
      16'h05: return 8'h1D;
      16'h07: return cs;
      16'h2C: return 8'hFF;
      16'h2D: return 8'h81;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic t_reset(input logic [7:0] f, input logic [7:0] s);
    @(posedge clk);
    cf <= f;
    cs <= s;
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(16'(ft), 16'(f), "fast trim");
    chk(16'(stt), 16'(s), "slow trim");
    rdc(8'h00, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_fuse();
    for (int i = 0; i < 4; i++) begin
      ldc(8'h09, fptr[i], i % 3, ~prog[i]);
      ldc(8'h00, fptr[i], 0, fptr[i][7:0] ^ 8'h96);
    end
    ldc(8'h09, 16'h0001, 3, 8'h01 ^ 8'h96);
    rdc(8'h00, 8'h00);
    wrr(8'h00, 8'h09);
    rdc(8'h00, 8'h09);
    wrr(8'h00, 8'h28);
    rdc(8'h00, 8'h00);
    ldc(8'h29, 16'h0001, 2, ~prog[0]);
    $display("fuse test done");
  endtask
  task automatic t_table();
    for (int i = 0; i < 13; i++)
      ldc(8'h21, tidx[i], i % 3, tbl(tidx[i]));
    ldc(8'h21, 16'h0000, 3, 8'h96);
    $display("table test done");
  endtask
  task automatic t_store();
    logic [15:0] p;
    p = 16'h3A75;
    wrr(8'h00, 8'h01);
    flr_core_model_i.issue(1'b1, p, 16'hBEEF, 3);
    @(negedge clk);
    chk(16'(pbuf.we), 16'h0001, "store we");
    chk(16'(pbuf.page), 16'(p[13:5]), "store page");
    chk(16'(pbuf.word), 16'(p[4:1]), "store word");
    chk(pbuf.data, 16'hBEEF, "store data");
    flr_core_model_i.issue(1'b1, p, 16'h1234, 1);
    @(negedge clk);
    chk(16'(pbuf.we), 16'h0000, "store after done");
    wrr(8'h00, 8'h09);
    flr_core_model_i.issue(1'b1, p, 16'h1234, 1);
    @(negedge clk);
    chk(16'(pbuf.we), 16'h0000, "store while read armed");
    rdc(8'h00, 8'h00);
    wrr(8'h00, 8'h01);
    flr_core_model_i.issue(1'b1, p, 16'h1234, 4);
    @(negedge clk);
    chk(16'(pbuf.we), 16'h0000, "store late");
    $display("store test done");
  endtask
  task automatic t_ee();
    logic [7:0] a [5] = '{8'h00, 8'h03, 8'h04, 8'hA6, 8'hFF};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      ee_addr <= a[i];
      @(posedge clk);
      @(negedge clk);
      chk(16'(ee_page), 16'(a[i][7:2]), "ee page");
      chk(16'(ee_byte), 16'(a[i][1:0]), "ee byte");
    end
    $display("eeprom test done");
  endtask
  task automatic t_regs();
    wrr(8'h01, 8'h5C);
    rdc(8'h01, 8'h5C);
    wrr(8'h02, 8'hA3);
    rdc(8'h02, 8'hA3);
    wrr(8'h7F, 8'h11);
    rdc(8'h7F, 8'h00);
    $display("register test done");
  endtask

  initial begin
    t_reset(8'h6A, 8'h35);
    t_fuse();
    t_table();
    t_store();
    t_ee();
    t_regs();
    t_reset(8'h94, 8'h0F);
    final_report();
  end
endmodule // tb_top
